// ==== verilog/hrs_pkg.sv ====
package hrs_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned OPER_US = 500;
   localparam int unsigned INACT_NS = 2000;
   localparam int unsigned ATTACH_MS = 100;
   localparam int unsigned EE_LOAD_US = 99500;
   localparam int unsigned SMB_LOAD_MS = 300;
   localparam int unsigned REQ_MS = 5;
   localparam int unsigned STRAP_NS = 1400;
   // Nanosecond times divide by the 25 ns period and round down to whole cycles.
   localparam int unsigned OPER_CYC = OPER_US * (CLK_HZ / 1000000);
   localparam int unsigned INACT_CYC = INACT_NS / 25;
   localparam int unsigned STRAP_CYC = STRAP_NS / 25;
   localparam int unsigned ATTACH_CYC = ATTACH_MS * (CLK_HZ / 1000);
   localparam int unsigned EE_LOAD_CYC = EE_LOAD_US * (CLK_HZ / 1000000);
   localparam int unsigned SMB_LOAD_CYC = SMB_LOAD_MS * (CLK_HZ / 1000);
   localparam int unsigned REQ_CYC = REQ_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W = 24;
   localparam logic [3:0] STRAP_RST = 4'h0;
   localparam logic [6:0] ADDR_RST = 7'h00;
   localparam logic [3:0] PWR_RST = 4'h0;
   typedef enum logic [2:0] {
      HRS_RESET = 3'h0,
      HRS_RECOVER = 3'h1,
      HRS_LOAD = 3'h3,
      HRS_SETUP = 3'h2,
      HRS_RUN = 3'h6,
      HRS_FAIL = 3'h7
   } hrs_state_t;
   typedef enum logic [1:0] {
      HRS_SRC_STRAP = 2'h0,
      HRS_SRC_EEPROM = 2'h1,
      HRS_SRC_SMBUS = 2'h2
   } hrs_src_t;
endpackage : hrs_pkg

// ==== verilog/hrs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module hrs_sequencer #(
   parameter int unsigned OPER_CYCLES = hrs_pkg::OPER_CYC,
   parameter int unsigned ATTACH_CYCLES = hrs_pkg::ATTACH_CYC,
   parameter int unsigned EE_LOAD_CYCLES = hrs_pkg::EE_LOAD_CYC,
   parameter int unsigned SMB_LOAD_CYCLES = hrs_pkg::SMB_LOAD_CYC,
   parameter int unsigned REQ_CYCLES = hrs_pkg::REQ_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Configuration select pins
   input wire logic smbus_disable,
   input wire logic smbus_present,
   input wire logic self_powered,
   // Configuration load handshake
   output logic load_start,
   input wire logic load_done,
   // Strap inputs on the port-A indicator pins
   input wire logic [3:0] host_a_indicator_pins_in,
   output logic [3:0] host_a_indicator_pins_oe,
   // Clock generation
   output logic osc_enable,
   output logic pll_enable,
   // Upstream link
   output logic phy_enable,
   output logic attach,
   input wire logic bus_reset,
   input wire logic suspend_req,
   output logic suspended,
   output logic [6:0] dev_addr,
   output logic configured,
   input wire logic set_addr,
   input wire logic [6:0] set_addr_val,
   input wire logic set_config,
   // Host request timing
   input wire logic req_start,
   input wire logic req_done,
   output logic req_busy,
   output logic req_timeout,
   // Downstream side
   output logic [3:0] port_enable,
   output logic [3:0] port_power_enable,
   input wire logic [3:0] port_power_req,
   output logic tt_flush,
   output logic downstream_reset,
   // Status
   output logic operational,
   output logic [1:0] cfg_source,
   output logic [3:0] strap_value,
   output logic config_error
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] brst_sync_q;
   logic [2:0] susp_sync_q;
   logic [2:0] done_sync_q;
   logic brst_q;
   logic susp_q;
   logic done_q;
   logic brst_prev_q;
   logic brst_rise;
   always_ff @(posedge clk) begin
      brst_sync_q <= {brst_sync_q[1:0], bus_reset};
      susp_sync_q <= {susp_sync_q[1:0], suspend_req};
      done_sync_q <= {done_sync_q[1:0], load_done};
   end
   // A change counts once the second and third stages agree.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         brst_q <= 1'b0;
         susp_q <= 1'b0;
         done_q <= 1'b0;
         brst_prev_q <= 1'b0;
      end else begin
         if (brst_sync_q[1] == brst_sync_q[2]) begin
            brst_q <= brst_sync_q[2];
         end
         if (susp_sync_q[1] == susp_sync_q[2]) begin
            susp_q <= susp_sync_q[2];
         end
         if (done_sync_q[1] == done_sync_q[2]) begin
            done_q <= done_sync_q[2];
         end
         brst_prev_q <= brst_q;
      end
   end
   assign brst_rise = brst_q && !brst_prev_q;

   // ****************************************
   // Start-up sequence
   // ****************************************
   hrs_pkg::hrs_state_t state_q;
   hrs_pkg::hrs_src_t src_q;
   logic [hrs_pkg::CNT_W-1:0] cnt_q;
   logic [hrs_pkg::CNT_W-1:0] since_rel_q;
   logic [3:0] strap_q;
   logic strap_taken_q;
   logic start_q;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= hrs_pkg::HRS_RESET;
         src_q <= hrs_pkg::HRS_SRC_STRAP;
         cnt_q <= '0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         unique case (state_q)
            hrs_pkg::HRS_RESET: begin
               state_q <= hrs_pkg::HRS_RECOVER;
               cnt_q <= '0;
            end
            hrs_pkg::HRS_RECOVER: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q >= hrs_pkg::CNT_W'(OPER_CYCLES - 1)) begin
                  cnt_q <= '0;
                  state_q <= hrs_pkg::HRS_LOAD;
                  if (smbus_disable) begin
                     src_q <= hrs_pkg::HRS_SRC_STRAP;
                  end else if (smbus_present) begin
                     src_q <= hrs_pkg::HRS_SRC_SMBUS;
                     start_q <= 1'b1;
                  end else begin
                     src_q <= hrs_pkg::HRS_SRC_EEPROM;
                     start_q <= 1'b1;
                  end
               end
            end
            hrs_pkg::HRS_LOAD: begin
               cnt_q <= cnt_q + 1'b1;
               // load limits
               // Strap mode completes once the straps have been captured, or when load_done is seen.
               if ((src_q == hrs_pkg::HRS_SRC_STRAP && strap_taken_q) || done_q) begin
                  cnt_q <= '0;
                  state_q <= hrs_pkg::HRS_SETUP;
               end else if (src_q == hrs_pkg::HRS_SRC_EEPROM &&
                            cnt_q >= hrs_pkg::CNT_W'(EE_LOAD_CYCLES - 1)) begin
                  state_q <= hrs_pkg::HRS_FAIL;
               end else if (src_q == hrs_pkg::HRS_SRC_SMBUS && !self_powered &&
                            cnt_q >= hrs_pkg::CNT_W'(SMB_LOAD_CYCLES - 1)) begin
                  state_q <= hrs_pkg::HRS_FAIL;
               end
            end
            hrs_pkg::HRS_SETUP: begin
               state_q <= hrs_pkg::HRS_RUN;
            end
            hrs_pkg::HRS_RUN: begin
               state_q <= hrs_pkg::HRS_RUN;
            end
            hrs_pkg::HRS_FAIL: begin
               state_q <= hrs_pkg::HRS_FAIL;
            end
            default: begin
               state_q <= hrs_pkg::HRS_RESET;
            end
         endcase
      end
   end
   assign load_start = start_q;

   // ****************************************
   // Strap capture
   // ****************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         strap_q <= hrs_pkg::STRAP_RST;
         strap_taken_q <= 1'b0;
         since_rel_q <= '0;
      end else begin
         if (since_rel_q != '1) begin
            since_rel_q <= since_rel_q + 1'b1;
         end
         if (!strap_taken_q && since_rel_q == hrs_pkg::CNT_W'(hrs_pkg::STRAP_CYC / 2)) begin
            strap_q <= host_a_indicator_pins_in;
            strap_taken_q <= 1'b1;
         end
      end
   end
   assign host_a_indicator_pins_oe = '0;

   // ****************************************
   // Upstream device state
   // ****************************************
   logic run;
   logic [6:0] addr_q;
   logic conf_q;
   logic susp_st_q;
   assign run = state_q == hrs_pkg::HRS_RUN;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         addr_q <= hrs_pkg::ADDR_RST;
         conf_q <= 1'b0;
         susp_st_q <= 1'b0;
      end else if (brst_q) begin
         addr_q <= hrs_pkg::ADDR_RST;
         conf_q <= 1'b0;
         susp_st_q <= 1'b0;
      end else if (run) begin
         if (set_addr) begin
            addr_q <= set_addr_val;
         end
         if (set_config) begin
            conf_q <= 1'b1;
         end
         susp_st_q <= susp_q;
      end
   end

   // ****************************************
   // Request completion timer
   // ****************************************
   logic [hrs_pkg::CNT_W-1:0] req_cnt_q;
   logic req_busy_q;
   logic req_to_q;
   always_ff @(posedge clk) begin
      if (!resetn || brst_q) begin
         req_cnt_q <= '0;
         req_busy_q <= 1'b0;
         req_to_q <= 1'b0;
      end else begin
         req_to_q <= 1'b0;
         if (req_busy_q) begin
            req_cnt_q <= req_cnt_q + 1'b1;
            if (req_done || req_cnt_q >= hrs_pkg::CNT_W'(REQ_CYCLES - 1)) begin
               req_busy_q <= 1'b0;
               req_to_q <= !req_done;
            end
         end else if (req_start && run) begin
            req_busy_q <= 1'b1;
            req_cnt_q <= '0;
         end
      end
   end

   // ****************************************
   // Downstream ports
   // ****************************************
   logic [3:0] pwr_q;
   logic flush_q;
   always_ff @(posedge clk) begin
      if (!resetn || brst_q) begin
         pwr_q <= hrs_pkg::PWR_RST;
      end else if (run && conf_q) begin
         pwr_q <= port_power_req;
      end else begin
         pwr_q <= hrs_pkg::PWR_RST;
      end
   end
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= brst_rise;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // clocks stopped while resetn is low
   assign osc_enable = resetn;
   assign pll_enable = resetn;
   assign phy_enable = resetn && state_q != hrs_pkg::HRS_RESET;
   assign attach = run;
   assign suspended = susp_st_q;
   assign dev_addr = addr_q;
   assign configured = conf_q;
   assign req_busy = req_busy_q;
   assign req_timeout = req_to_q;
   assign port_enable = pwr_q;
   assign port_power_enable = pwr_q;
   assign tt_flush = flush_q;
   assign downstream_reset = 1'b0;
   assign operational = state_q != hrs_pkg::HRS_RESET && state_q != hrs_pkg::HRS_RECOVER;
   assign cfg_source = src_q;
   assign strap_value = strap_q;
   assign config_error = state_q == hrs_pkg::HRS_FAIL;
endmodule : hrs_sequencer
`default_nettype wire

// ==== tb/hrs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module hrs_monitor #(
   parameter int OPER_CYCLES = 20,
   parameter int REQ_CYCLES = 50
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Watched signals
   input wire logic smbus_disable,
   input wire logic load_start,
   input wire logic load_done,
   input wire logic bus_reset,
   input wire logic [3:0] host_a_indicator_pins_oe,
   input wire logic osc_enable,
   input wire logic pll_enable,
   input wire logic phy_enable,
   input wire logic attach,
   input wire logic suspended,
   input wire logic [6:0] dev_addr,
   input wire logic configured,
   input wire logic req_busy,
   input wire logic [3:0] port_power_enable,
   input wire logic tt_flush,
   input wire logic downstream_reset,
   input wire logic operational,
   input wire logic [1:0] cfg_source,
   input wire logic config_error
);
   localparam int OPER_MAX = OPER_CYCLES + 4;
   localparam int REQ_MAX = REQ_CYCLES + 2;
   default clocking cb @(posedge clk);
   endclocking
   // ****************************************
   // Assertions
   // ****************************************
   a_rst_ports_off: assert property (!resetn |=> port_power_enable == 4'h0)
      else $error("port power on in reset");
   a_rst_phy_off: assert property (!resetn |=> !phy_enable && !attach && !req_busy)
      else $error("link active in reset");
   a_rst_clk_halt: assert property (!resetn |-> !osc_enable && !pll_enable)
      else $error("clocks run in reset");
   a_pins_released: assert property (host_a_indicator_pins_oe == 4'h0)
      else $error("indicator pins driven");
   a_rst_regs_zero: assert property (!resetn |=> dev_addr == 7'h00 && !configured
      && cfg_source == 2'h0 && !config_error)
      else $error("state not cleared");
   a_oper_bound: assert property (disable iff (!resetn) $rose(resetn) |-> ##[1:OPER_MAX] operational)
      else $error("not operational in time");
   a_attach_after_load: assert property (disable iff (!resetn) $rose(attach) |->
      operational && (cfg_source == 2'h0 || $past(load_done, 3)))
      else $error("attach before config");
   a_load_pulse: assert property (disable iff (!resetn) load_start |-> !smbus_disable ##1 !load_start)
      else $error("bad load start");
   a_req_bound: assert property (disable iff (!resetn) $rose(req_busy) |-> ##[1:REQ_MAX] !req_busy)
      else $error("request not ended");
   a_bus_rst_clear: assert property (disable iff (!resetn) bus_reset [*8] |-> dev_addr == 7'h00
      && !configured && port_power_enable == 4'h0 && !suspended)
      else $error("bus reset left state");
   a_no_fwd_reset: assert property (downstream_reset == 1'b0)
      else $error("reset forwarded");
   a_tt_flush: assert property (disable iff (!resetn) $rose(bus_reset) |-> ##[2:8] tt_flush)
      else $error("no buffer flush");
endmodule // hrs_monitor
bind hrs_sequencer hrs_monitor #(.OPER_CYCLES(OPER_CYCLES), .REQ_CYCLES(REQ_CYCLES)) mon (
   .clk, .resetn, .smbus_disable, .load_start, .load_done, .bus_reset,
   .host_a_indicator_pins_oe, .osc_enable, .pll_enable, .phy_enable, .attach,
   .suspended, .dev_addr, .configured, .req_busy, .port_power_enable, .tt_flush,
   .downstream_reset, .operational, .cfg_source, .config_error
);
`default_nettype wire

// ==== tb/hrs_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module hrs_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Load handshake
   input wire logic load_start,
   input wire logic [7:0] lat,
   output logic load_done
);
   logic [7:0] cnt_q;
   logic run_q;
   // Load time chosen by the host.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         run_q <= 1'b0;
         cnt_q <= 8'h00;
         load_done <= 1'b0;
      end else if (load_start) begin
         run_q <= 1'b1;
         cnt_q <= lat;
      end else if (run_q && cnt_q == 8'h00) begin
         load_done <= 1'b1;
      end else if (run_q) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule // hrs_partner
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int OPER = 20;
   localparam int LOADC = 100;
   localparam int REQC = 50;
   logic clk, resetn, smbus_disable, smbus_present, self_powered, load_start, load_done;
   logic bus_reset, suspend_req, set_addr, set_config, req_start, req_done, phy_enable;
   logic attach, suspended, configured, req_busy, req_timeout, tt_flush, downstream_reset;
   logic operational, config_error, osc_enable, pll_enable, att_d;
   logic [3:0] pins, pins_oe, port_enable, ppe, ppr, strap_value;
   logic [6:0] dev_addr, set_addr_val;
   logic [1:0] cfg_source;
   logic [7:0] lat;
   logic [5:0] exp_q[$];
   int error_cnt = 0;
   int checks = 0;
   int flush_n = 0;
   int m;
   hrs_sequencer #(.OPER_CYCLES(OPER), .EE_LOAD_CYCLES(LOADC), .SMB_LOAD_CYCLES(LOADC),
      .REQ_CYCLES(REQC)) uut (
      .clk, .resetn, .smbus_disable, .smbus_present, .self_powered, .load_start,
      .load_done, .host_a_indicator_pins_in(pins), .host_a_indicator_pins_oe(pins_oe),
      .osc_enable, .pll_enable, .phy_enable, .attach, .bus_reset, .suspend_req,
      .suspended, .dev_addr, .configured, .set_addr, .set_addr_val, .set_config,
      .req_start, .req_done, .req_busy, .req_timeout, .port_enable,
      .port_power_enable(ppe), .port_power_req(ppr), .tt_flush, .downstream_reset,
      .operational, .cfg_source, .strap_value, .config_error);
   hrs_partner host (.clk, .resetn, .load_start, .lat, .load_done);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(string nm, logic [15:0] e, logic [15:0] s);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_for(ref logic s, input int n);
      for (int i = 0; i < n && s !== 1'b1; i++) @(negedge clk);
      check("wait", 1'b1, s);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic boot(logic dis, logic pres, logic sp, logic [7:0] l);
      @(negedge clk);
      resetn = 1'b0;
      smbus_disable = dis;
      smbus_present = pres;
      self_powered = sp;
      lat = l;
      pins = dis ? 4'($urandom) : 4'h0;
      repeat (40) @(negedge clk);
      resetn = 1'b1;
   endtask
   // The watcher pairs each attach with the oldest expected configuration.
   always @(posedge clk) begin
      att_d <= attach;
      if (tt_flush === 1'b1) flush_n++;
      if (attach === 1'b1 && att_d === 1'b0) begin
         check("cfg", exp_q.size() > 0 ? exp_q.pop_front() : 6'h3F, {cfg_source, strap_value});
      end
   end
   initial begin
      #(25 * 8000);
      error_cnt++;
      $display("mismatch watchdog expected done seen hang");
      results;
   end
   initial begin
      {resetn, smbus_disable, smbus_present, self_powered, bus_reset, suspend_req} = 6'h00;
      {set_addr, set_config, req_start, req_done, pins, ppr, set_addr_val, lat} = 28'h0000000;
      void'($urandom(32'h3DAB5D23));
      repeat (12) @(negedge clk);
      for (m = 0; m < 3; m++) begin
         boot(m == 0, m == 2, 1'b0, 8'(10 + $urandom_range(40)));
         exp_q.push_back({2'(m), pins});
         wait_for(attach, OPER + 80);
         $display("test mode %0d done", m);
      end
      boot(1'b0, 1'b0, 1'b0, 8'hC8);
      repeat (OPER + LOADC + 20) @(negedge clk);
      check("config_error", 1'b1, config_error);
      check("attach", 1'b0, attach);
      $display("test load timeout done");
      boot(1'b0, 1'b1, 1'b1, 8'hC8);
      exp_q.push_back(6'h20);
      wait_for(attach, OPER + 260);
      $display("test self powered done");
      set_addr_val = 7'($urandom_range(1, 127));
      ppr = 4'($urandom_range(1, 15));
      pulse(set_addr);
      pulse(set_config);
      repeat (3) @(negedge clk);
      check("addr power", {set_addr_val, 1'b1, ppr, ppr}, {dev_addr, configured, ppe, port_enable});
      pulse(req_start);
      check("req_busy", 1'b1, req_busy);
      repeat (9) @(negedge clk);
      pulse(req_done);
      @(negedge clk);
      check("req_busy", 1'b0, req_busy);
      pulse(req_start);
      wait_for(req_timeout, REQC + 5);
      $display("test requests done");
      suspend_req = 1'b1;
      repeat (10) @(negedge clk);
      check("suspended", 1'b1, suspended);
      flush_n = 0;
      bus_reset = 1'b1;
      repeat (12) @(negedge clk);
      check("bus reset", 13'h0000, {dev_addr, configured, ppe, suspended});
      check("downstream_reset", 1'b0, downstream_reset);
      {bus_reset, suspend_req} = 2'h0;
      repeat (4) @(negedge clk);
      check("flush", 16'h0001, 16'(flush_n));
      $display("test bus reset done");
      results;
   end
endmodule // tb
`default_nettype wire
